// File: hw/adcsp_consts.vh
// constants for the dual-channel converter serial port: frame timing,
// control word layout and result width.
// assumes it is included by bare name from every design file that needs it.
//
// Summary of operation
// - a high-to-low change of the select line starts a conversion run at once.
// - with select held low, 16-clock frames follow back to back until select goes high.
// - each result bit is driven onto the serial output on a falling serial clock edge.
// - control bits on the serial input are captured on rising serial clock edges.
// - each result is 10 bits of plain binary, most significant bit first.
// - the control word selects one input channel or both channels in turn.
// - the serial clock alone paces acquisition, approximation steps and shifting out.
// - one sample frame is 16 serial clocks: 3 acquisition, 10 approximation and 3 trailing.
`ifndef ADCSP_CONSTS_VH
`define ADCSP_CONSTS_VH

// ----------------------------------------------------------------------
// frame timing, in serial clock falling edges
// ----------------------------------------------------------------------
`define ADCSP_FRAME_LEN   5'd16
`define ADCSP_ACQ_LEN     5'd3
`define ADCSP_SAR_FIRST   5'd4
`define ADCSP_SAR_LAST    5'd13

// ----------------------------------------------------------------------
// result and control word layout
// ----------------------------------------------------------------------
`define ADCSP_RES_W       10
`define ADCSP_CTRL_W      8
`define ADCSP_CTRL_LEN    5'd8
`define ADCSP_CHAN_BIT    3
`define ADCSP_DUAL_BIT    4
`define ADCSP_CTRL_RST    8'h00
`define ADCSP_RES_RST     10'h000

`endif

// File: hw/adcsp_buf.v
// two-entry result buffer with valid/ready on both sides.
// assumes one clock, asynchronous active-low reset; outputs are flops.
`timescale 1ns/1ps
module adcsp_buf #(
  parameter W = 11
) (
  input  wire         i_clk,     // system clock
  input  wire         i_resetn,  // async reset, active low
  input  wire [W-1:0] i_data,    // word from the converter
  input  wire         i_valid,   // word offered
  output wire         o_ready,   // room for a word
  output wire [W-1:0] o_data,    // head word
  output wire         o_valid,   // head word present
  input  wire         i_ready    // drain side takes the head
);

  reg [W-1:0] head_q;
  reg [W-1:0] tail_q;
  reg         head_vld_q;
  reg         tail_vld_q;
  wire        push;
  wire        pop;

  // ----------------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------------
  // ready from a flop only: full means the tail entry is taken
  assign o_ready = ~tail_vld_q;
  assign o_data  = head_q;
  assign o_valid = head_vld_q;
  assign push    = i_valid & ~tail_vld_q;
  assign pop     = head_vld_q & i_ready;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  // head always holds the oldest word, so the output never needs a mux
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      head_q     <= {W{1'b0}};
      tail_q     <= {W{1'b0}};
      head_vld_q <= 1'b0;
      tail_vld_q <= 1'b0;
    end else if (pop) begin
      if (tail_vld_q) begin
        head_q     <= tail_q;
        tail_vld_q <= 1'b0;
      end else begin
        head_q     <= i_data;
        head_vld_q <= push;
      end
    end else if (push) begin
      if (!head_vld_q) begin
        head_q     <= i_data;
        head_vld_q <= 1'b1;
      end else begin
        tail_q     <= i_data;
        tail_vld_q <= 1'b1;
      end
    end
  end

endmodule

// File: hw/adcsp_top.v
// serial port and successive-approximation sequencer of a two-input
// 10-bit converter, plus a buffered parallel copy of each result not lost to an overrun.
// assumes select, serial clock, serial input and the two quantised input
// levels arrive asynchronously; the serial clock must be well below i_clk/4.
`timescale 1ns/1ps
`include "adcsp_consts.vh"
module adcsp_top (
  input  wire        i_clk,              // 50 MHz system clock
  input  wire        i_resetn,           // async reset, active low
  input  wire        i_cs_n,             // select pin, active low
  input  wire        i_sclk,             // serial clock pin from host
  input  wire        i_din,              // serial control input pin
  input  wire [9:0]  i_analog_input_a,   // quantised level of input a
  input  wire [9:0]  i_analog_input_b,   // quantised level of input b
  output reg         o_dout,             // serial result output
  output reg         o_dout_oe,          // high while driving o_dout
  output wire [9:0]  o_result_data,      // buffered result word
  output wire        o_result_chan,      // channel of buffered result
  output wire        o_result_valid,     // buffered result present
  input  wire        i_result_ready,     // user takes the result
  output reg         o_overrun,          // pulse: a result was lost
  output reg         o_frame_busy        // high while a run is active
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  reg        cs_n_s1_q, cs_n_s2_q, cs_n_s3_q;
  reg        sclk_s1_q, sclk_s2_q, sclk_s3_q;
  reg        din_s1_q,  din_s2_q;
  reg  [9:0] ain_a_s1_q, ain_a_s2_q;
  reg  [9:0] ain_b_s1_q, ain_b_s2_q;
  wire       cs_fall;
  wire       cs_rise;
  wire       sclk_fall;
  wire       sclk_rise;

  // the third stage only serves the edge detectors, never the first stage
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_n_s1_q  <= 1'b1;
      cs_n_s2_q  <= 1'b1;
      cs_n_s3_q  <= 1'b1;
      sclk_s1_q  <= 1'b1;
      sclk_s2_q  <= 1'b1;
      sclk_s3_q  <= 1'b1;
      din_s1_q   <= 1'b0;
      din_s2_q   <= 1'b0;
      ain_a_s1_q <= `ADCSP_RES_RST;
      ain_a_s2_q <= `ADCSP_RES_RST;
      ain_b_s1_q <= `ADCSP_RES_RST;
      ain_b_s2_q <= `ADCSP_RES_RST;
    end else begin
      cs_n_s1_q  <= i_cs_n;
      cs_n_s2_q  <= cs_n_s1_q;
      cs_n_s3_q  <= cs_n_s2_q;
      sclk_s1_q  <= i_sclk;
      sclk_s2_q  <= sclk_s1_q;
      sclk_s3_q  <= sclk_s2_q;
      din_s1_q   <= i_din;
      din_s2_q   <= din_s1_q;
      ain_a_s1_q <= i_analog_input_a;
      ain_a_s2_q <= ain_a_s1_q;
      ain_b_s1_q <= i_analog_input_b;
      ain_b_s2_q <= ain_b_s1_q;
    end
  end

  assign cs_fall   = cs_n_s3_q & ~cs_n_s2_q;
  assign cs_rise   = ~cs_n_s3_q & cs_n_s2_q;
  assign sclk_fall = sclk_s3_q & ~sclk_s2_q & ~cs_n_s2_q;
  assign sclk_rise = ~sclk_s3_q & sclk_s2_q & ~cs_n_s2_q;

  // ----------------------------------------------------------------------
  // frame sequencer state
  // ----------------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg                      state_q;
  reg  [4:0]               cnt_q;      // falling edges seen in this frame
  reg  [`ADCSP_CTRL_W-1:0] ctrl_q;     // committed control word
  reg  [`ADCSP_CTRL_W-1:0] ctrl_sh_q;  // control word being shifted in
  reg                      chan_q;     // channel of the current frame
  reg  [9:0]               hold_q;     // held input level
  reg  [9:0]               sar_q;      // approximation register
  reg                      pend_q;     // finished result awaiting buffer
  reg  [10:0]              pend_word_q;
  wire [4:0]               edge_num;
  wire [9:0]               trial;
  wire                     keep_bit;
  wire                     last_edge;
  wire                     buf_ready;
  wire                     next_chan;

  assign edge_num  = cnt_q + 5'd1;
  assign trial     = sar_q | (10'h001 << (`ADCSP_SAR_LAST - edge_num));
  assign keep_bit  = (trial <= hold_q);
  assign last_edge = (edge_num == `ADCSP_FRAME_LEN);
  // dual mode alternates channels, otherwise the written channel is used
  assign next_chan = ctrl_sh_q[`ADCSP_DUAL_BIT] ? ~chan_q
                                                : ctrl_sh_q[`ADCSP_CHAN_BIT];

  // ----------------------------------------------------------------------
  // run control, approximation and serial output
  // ----------------------------------------------------------------------
  // approximation and shifting below are paced by detected serial clock edges; run start and stop by select edges
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q      <= ST_IDLE;
      cnt_q        <= 5'd0;
      ctrl_q       <= `ADCSP_CTRL_RST;
      ctrl_sh_q    <= `ADCSP_CTRL_RST;
      chan_q       <= 1'b0;
      hold_q       <= `ADCSP_RES_RST;
      sar_q        <= `ADCSP_RES_RST;
      pend_q       <= 1'b0;
      pend_word_q  <= 11'h000;
      o_dout       <= 1'b0;
      o_dout_oe    <= 1'b0;
      o_overrun    <= 1'b0;
      o_frame_busy <= 1'b0;
    end else begin
      o_overrun <= 1'b0;
      if (pend_q && buf_ready) begin
        pend_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (cs_fall) begin
            state_q      <= ST_RUN;
            cnt_q        <= 5'd0;
            chan_q       <= ctrl_q[`ADCSP_CHAN_BIT];
            ctrl_sh_q    <= ctrl_q;
            o_dout       <= 1'b0;
            o_dout_oe    <= 1'b1;
            o_frame_busy <= 1'b1;
          end
        end
        ST_RUN: begin
          if (cs_rise) begin
            state_q      <= ST_IDLE;
            o_dout_oe    <= 1'b0;
            o_frame_busy <= 1'b0;
          end else if (sclk_rise) begin
            if (cnt_q >= 5'd1 && cnt_q <= `ADCSP_CTRL_LEN) begin
              ctrl_sh_q <= {ctrl_sh_q[`ADCSP_CTRL_W-2:0], din_s2_q};
            end
          end else if (sclk_fall) begin
            cnt_q  <= last_edge ? 5'd0 : edge_num;
            o_dout <= 1'b0;
            if (edge_num == `ADCSP_ACQ_LEN) begin
              hold_q <= chan_q ? ain_b_s2_q : ain_a_s2_q;
              sar_q  <= `ADCSP_RES_RST;
            end
            if (edge_num >= `ADCSP_SAR_FIRST && edge_num <= `ADCSP_SAR_LAST) begin
              o_dout <= keep_bit;
              if (keep_bit) begin
                sar_q <= trial;
              end
            end
            // a result still waiting when the next one lands is lost
            if (edge_num == `ADCSP_SAR_LAST) begin
              pend_q      <= 1'b1;
              pend_word_q <= {chan_q, keep_bit ? trial : sar_q};
              o_overrun   <= pend_q & ~buf_ready;
            end
            if (last_edge) begin
              ctrl_q <= ctrl_sh_q;
              chan_q <= next_chan;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // result buffer
  // ----------------------------------------------------------------------
  // a full buffer leaves the finished word in pend_word_q until room opens or the next result overwrites it
  adcsp_buf #(
    .W (11)
  ) u_buf (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_data   (pend_word_q),
    .i_valid  (pend_q),
    .o_ready  (buf_ready),
    .o_data   ({o_result_chan, o_result_data}),
    .o_valid  (o_result_valid),
    .i_ready  (i_result_ready)
  );

endmodule

// File: sim/adcsp_chk.sv
// checker for adcsp_top, sees its ports only.
// assumes one clock i_clk and async active-low i_resetn.
`timescale 1ns/1ps
module adcsp_chk (
  input logic       i_clk,          // clock
  input logic       i_resetn,       // reset
  input logic       i_cs_n,         // select
  input logic       i_sclk,         // serial clock
  input logic       o_dout,         // serial data
  input logic       o_dout_oe,      // data enable
  input logic [9:0] o_result_data,  // head data
  input logic       o_result_chan,  // head channel
  input logic       o_result_valid, // head valid
  input logic       i_result_ready, // drain
  input logic       o_overrun,      // lost word
  input logic       o_frame_busy    // run active
);
  // ----------
  // helper
  // ----------
  logic       sclk_q;
  logic [3:0] age_q;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // cycles since the serial clock fell; saturates so idle gaps stay quiet
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q <= 1'b1;
      age_q  <= 4'hf;
    end else begin
      sclk_q <= i_sclk;
      if (sclk_q && !i_sclk)
        age_q <= 4'h0;
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
    end
  end
  // ----------
  // properties
  // ----------
  property p_start; $fell(i_cs_n) |-> ##[2:5] o_dout_oe && o_frame_busy; endproperty
  a_start: assert property (p_start) else $error("run did not start");
  property p_stop; $rose(i_cs_n) |-> ##[2:5] !o_frame_busy && !o_dout_oe; endproperty
  a_stop: assert property (p_stop) else $error("run did not stop");
  property p_hold; o_frame_busy && !i_cs_n |=> o_frame_busy; endproperty
  a_hold: assert property (p_hold) else $error("run ended while selected");
  property p_idle; i_cs_n [*6] |-> !o_dout_oe && !o_frame_busy; endproperty
  a_idle: assert property (p_idle) else $error("active while deselected");
  property p_edge;
    $changed(o_dout) && o_dout_oe && $past(o_dout_oe) |-> age_q >= 4'h1 && age_q <= 4'h5;
  endproperty
  a_edge: assert property (p_edge) else $error("data moved off a clock fall");
  property p_acq; $rose(o_dout_oe) |-> !o_dout; endproperty
  a_acq: assert property (p_acq) else $error("run opened with data high");
  property p_head;
    o_result_valid && !i_result_ready |=>
      o_result_valid && $stable({o_result_chan, o_result_data});
  endproperty
  a_head: assert property (p_head) else $error("head word changed");
  property p_ovr; o_overrun |=> !o_overrun; endproperty
  a_ovr: assert property (p_ovr) else $error("overrun not a pulse");
endmodule

// File: sim/adcsp_host.sv
// host serial controller model: select, serial clock and control bits
// out, result bits in. assumes i_clk at 50 MHz, bench calls its tasks.
`timescale 1ns/1ps
module adcsp_host #(
  parameter HALF = 4
) (
  input  wire i_clk,  // system clock
  input  wire i_dout, // result bit
  output reg  o_cs_n, // select
  output reg  o_sclk, // serial clock
  output reg  o_din   // control bit
);
  // idle: not selected, serial clock parked high
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din  = 1'b0;
  end
  // select edge, with settle time after it
  task sel(input logic v);
    begin
      @(negedge i_clk);
      o_cs_n = v;
      repeat (8) @(negedge i_clk);
    end
  endtask
  // n falls; n below 16 cuts the frame short. a bit is taken just before
  // the next fall; past rise 8 din toggles, which the device must ignore
  task frame(input logic [7:0] ctrl, input integer n, output logic [9:0] w);
    integer k;
    begin
      w = 10'h000;
      for (k = 1; k <= n; k = k + 1) begin
        if (k >= 5 && k <= 14)
          w = {w[8:0], i_dout};
        o_sclk = 1'b0;
        o_din  = (k <= 8) ? ctrl[8-k] : ~o_din;
        repeat (HALF) @(negedge i_clk);
        o_sclk = 1'b1;
        repeat (HALF) @(negedge i_clk);
      end
    end
  endtask
endmodule

// File: sim/adcsp_top_tb.sv
// bench for adcsp_top: host model on the serial side, bench drains results.
// assumes a 20 ns clock and a 160 ns serial clock.
`timescale 1ns/1ps
module adcsp_top_tb;
  logic       i_clk = 1'b0;
  logic       i_resetn;
  logic [9:0] ain_a;
  logic [9:0] ain_b;
  logic       rdy;
  logic [9:0] w;
  wire        cs_n, sclk, din, dout, oe, rchan, rvalid, ovr, busy;
  wire  [9:0] rdata;
  integer     n_errors = 0;
  integer     checked = 0;
  integer     n_ovr = 0;
  adcsp_host host_u (.i_clk(i_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  adcsp_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_din(din), .i_analog_input_a(ain_a), .i_analog_input_b(ain_b), .o_dout(dout),
    .o_dout_oe(oe), .o_result_data(rdata), .o_result_chan(rchan), .o_result_valid(rvalid),
    .i_result_ready(rdy), .o_overrun(ovr), .o_frame_busy(busy));
  // clock, and a tally of lost-word pulses
  always #10 i_clk = ~i_clk;
  // counted mid-cycle so the pulse is read where it is settled
  always @(negedge i_clk) if (ovr === 1'b1) n_ovr = n_ovr + 1;
  task chk(input logic [10:0] got, input logic [10:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // take one word; the bounded wait covers a result still in flight
  task pop(input logic [10:0] exp);
    integer t;
    begin
      for (t = 0; t < 300 && rvalid !== 1'b1; t = t + 1) @(negedge i_clk);
      chk({rchan, rdata}, exp);
      rdy = 1'b1;
      @(negedge i_clk);
      rdy = 1'b0;
      @(negedge i_clk); // a cycle with ready low keeps two takes apart
    end
  endtask
  task t_single;
    begin
      ain_a = 10'h2a5;
      ain_b = 10'h15a;
      host_u.sel(1'b0);
      host_u.frame(8'h08, 16, w);
      chk({1'b0, w}, {1'b0, ain_a});
      host_u.frame(8'h08, 16, w);
      chk({1'b0, w}, {1'b0, ain_b});
      host_u.frame(8'h00, 16, w);
      chk({1'b0, w}, {1'b0, ain_b});
      host_u.sel(1'b1);
      chk({10'h000, oe}, 11'h000);
      pop({1'b0, ain_a});
      pop({1'b1, ain_b});
      pop({1'b1, ain_b});
      $display("t_single done");
    end
  endtask
  // dual mode: channels alternate starting from the committed channel a
  task t_dual;
    begin
      ain_a = 10'h3ff;
      ain_b = 10'h2a5;
      host_u.sel(1'b0);
      host_u.frame(8'h10, 16, w);
      chk({1'b0, w}, {1'b0, ain_a});
      host_u.frame(8'h10, 16, w);
      chk({1'b0, w}, {1'b0, ain_b});
      host_u.frame(8'h00, 16, w);
      chk({1'b0, w}, {1'b0, ain_a});
      host_u.sel(1'b1);
      pop({1'b0, ain_a});
      pop({1'b1, ain_b});
      pop({1'b0, ain_a});
      $display("t_dual done");
    end
  endtask
  // channel bit goes out at rise 5, then select drops mid-frame
  task t_abort;
    begin
      host_u.sel(1'b0);
      host_u.frame(8'h08, 6, w);
      chk({10'h000, busy}, 11'h001);
      host_u.sel(1'b1);
      chk({9'h000, busy, rvalid}, 11'h000);
      host_u.sel(1'b0);
      host_u.frame(8'h00, 16, w);
      host_u.sel(1'b1);
      chk({1'b0, w}, {1'b0, ain_a});
      pop({1'b0, ain_a});
      $display("t_abort done");
    end
  endtask
  // reset in mid-frame: committed channel b and the queued word are cleared
  task t_reset;
    begin
      host_u.sel(1'b0);
      host_u.frame(8'h08, 16, w);
      chk({1'b0, w}, {1'b0, ain_a});
      host_u.frame(8'h00, 6, w);
      i_resetn = 1'b0;
      host_u.sel(1'b1);
      chk({8'h00, busy, oe, rvalid}, 11'h000);
      i_resetn = 1'b1;
      host_u.sel(1'b0);
      host_u.frame(8'h00, 16, w);
      host_u.sel(1'b1);
      chk({1'b0, w}, {1'b0, ain_a});
      pop({1'b0, ain_a});
      $display("t_reset done");
    end
  endtask
  // drain stalled for five frames: words 1, 2 and 5 survive
  task t_ovr;
    logic [9:0] k;
    begin
      host_u.sel(1'b0);
      for (k = 10'h000; k < 10'h005; k = k + 10'h001) begin
        ain_a = 10'h100 + k;
        host_u.frame(8'h00, 16, w);
        chk({1'b0, w}, {1'b0, ain_a});
      end
      host_u.sel(1'b1);
      chk(n_ovr[10:0], 11'h002);
      pop(11'h100);
      pop(11'h101);
      pop(11'h104);
      chk({10'h000, rvalid}, 11'h000);
      $display("t_ovr done");
    end
  endtask
  task test_done;
    begin
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // main sequence, and a watchdog at ten times the expected length
  initial begin
    i_resetn = 1'b0;
    ain_a    = 10'h000;
    ain_b    = 10'h000;
    rdy      = 1'b0;
    repeat (20) @(negedge i_clk);
    i_resetn = 1'b1;
    t_single;
    t_dual;
    t_abort;
    t_reset;
    t_ovr;
    test_done;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule
bind adcsp_top adcsp_chk chk_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
  .i_sclk(i_sclk), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_result_data(o_result_data),
  .o_result_chan(o_result_chan), .o_result_valid(o_result_valid),
  .i_result_ready(i_result_ready), .o_overrun(o_overrun), .o_frame_busy(o_frame_busy));
